// ==== rtl/zaoc_checker.sv ====
/*
 * Zone access override checker: holds the zone override register behind
 * the special-register move port and judges each load, store, fetch and
 * cache-control operation against it, one cycle after the request.
 * Assumes every request comes with the matching translation entry of a
 * hit; lookup, misses and interrupt vectoring live outside.
 */
`timescale 1ns/1ns

module zaoc_checker
(
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   // Special-register move port
   input  wire logic [9:0]            spr_num,
   input  wire logic                  spr_wr_en,
   input  wire logic                  spr_rd_en,
   input  wire logic [31:0]           spr_wdata,
   output logic      [31:0]           spr_rdata,
   output logic                       spr_priv_fault,
   // Machine state
   input  wire logic                  problem_state,
   input  wire logic                  data_translate,
   input  wire logic                  instr_translate,
   // Check request with the matching entry
   input  wire logic                  req_valid,
   input  wire zaoc_pkg::zaoc_op_t    req_op,
   input  wire logic [3:0]            zone_select,
   input  wire logic                  tlb_wr,
   input  wire logic                  execute_permit,
   // Verdict
   output logic                       rsp_valid,
   output logic                       rsp_allow,
   output logic                       rsp_dsi,
   output logic                       rsp_isi,
   output logic                       rsp_noop,
   output logic      [1:0]            rsp_zone_field
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0] zone_override_reg;
      logic [31:0] spr_rdata_reg;
      logic        spr_fault_reg;
      logic        rsp_valid_reg;
      logic        rsp_allow_reg;
      logic        rsp_dsi_reg;
      logic        rsp_isi_reg;
      logic        rsp_noop_reg;
      logic [1:0]  rsp_zone_reg;
   } zaoc_state_t;

   zaoc_state_t st_reg;
   zaoc_state_t st_next;

   logic [1:0]  zone_now;
   logic        zone_block;
   logic        wr_ok;
   logic        ex_ok;
   logic        xlate_on;
   logic        deny;
   logic        silent;
   logic        spr_hit;

   // Field n sits at big-endian bits 2n..2n+1, i.e. vector bits 31-2n..30-2n
   function automatic logic [1:0] zaoc_zone_pick(input logic [31:0] zreg, input logic [3:0] sel);
      logic [4:0]  sh;
      logic [31:0] tmp;
      sh  = 5'h1E - {sel, 1'b0};
      tmp = zreg >> sh;
      return tmp[1:0];
   endfunction : zaoc_zone_pick

   assign zone_now = zaoc_zone_pick(st_reg.zone_override_reg, zone_select);

   zaoc_zone_rights u_rights
   (
      .zone_field     (zone_now),
      .problem_state  (problem_state),
      .tlb_wr         (tlb_wr),
      .execute_permit (execute_permit),
      .zone_block     (zone_block),
      .wr_ok          (wr_ok),
      .ex_ok          (ex_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      st_next = st_reg;
      deny    = 1'b0;
      silent  = 1'b0;
      spr_hit = (spr_num == zaoc_pkg::ZONE_OVR_SPR_NUM);

      // A write and a read in one cycle: the read returns the old value
      st_next.spr_fault_reg = (spr_wr_en || spr_rd_en) && spr_hit && problem_state;
      if (spr_wr_en && spr_hit && !problem_state)
      begin
         st_next.zone_override_reg = spr_wdata;
      end
      if (spr_rd_en)
      begin
         // Unmapped numbers and user-mode reads return zero
         st_next.spr_rdata_reg = (spr_hit && !problem_state) ? st_reg.zone_override_reg : 32'h0000_0000;
      end

      xlate_on = (req_op == zaoc_pkg::OP_IFETCH) ? instr_translate : data_translate;

      unique case (req_op)
         zaoc_pkg::OP_LOAD         : deny = zone_block;
         zaoc_pkg::OP_STORE        : deny = zone_block || !wr_ok;
         zaoc_pkg::OP_IFETCH       : deny = zone_block || !ex_ok;
         zaoc_pkg::OP_LINE_ALLOC   : silent = zone_block || !wr_ok;
         zaoc_pkg::OP_LINE_FLUSH   : deny = zone_block;
         zaoc_pkg::OP_LINE_INVAL   : deny = !wr_ok;
         zaoc_pkg::OP_LINE_STORE   : deny = zone_block;
         zaoc_pkg::OP_TOUCH        : silent = zone_block;
         zaoc_pkg::OP_TOUCH_ST     : silent = zone_block;
         zaoc_pkg::OP_LINE_ZERO    : deny = zone_block || !wr_ok;
         zaoc_pkg::OP_DCLASS_INVAL : deny = !wr_ok;
         zaoc_pkg::OP_DCACHE_READ  : deny = 1'b0;
         zaoc_pkg::OP_ILINE_INVAL  : deny = 1'b0;
         zaoc_pkg::OP_ITOUCH       : silent = zone_block;
         // Instruction cache never holds modified data, so no write check
         zaoc_pkg::OP_ICLASS_INVAL : deny = 1'b0;
         zaoc_pkg::OP_ICACHE_READ  : deny = 1'b0;
      endcase

      // Real mode bypasses every check
      if (!xlate_on)
      begin
         deny   = 1'b0;
         silent = 1'b0;
      end

      st_next.rsp_valid_reg = req_valid;
      if (req_valid)
      begin
         st_next.rsp_allow_reg = !deny && !silent;
         st_next.rsp_noop_reg  = silent;
         // Fetch failures are instruction-storage; every cache op is data-side
         st_next.rsp_isi_reg   = deny && (req_op == zaoc_pkg::OP_IFETCH);
         st_next.rsp_dsi_reg   = deny && (req_op != zaoc_pkg::OP_IFETCH);
         st_next.rsp_zone_reg  = zone_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_reg <= '{zone_override_reg: zaoc_pkg::ZONE_OVR_RESET, default: '0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign spr_rdata      = st_reg.spr_rdata_reg;
   assign spr_priv_fault = st_reg.spr_fault_reg;
   assign rsp_valid      = st_reg.rsp_valid_reg;
   assign rsp_allow      = st_reg.rsp_allow_reg;
   assign rsp_dsi        = st_reg.rsp_dsi_reg;
   assign rsp_isi        = st_reg.rsp_isi_reg;
   assign rsp_noop       = st_reg.rsp_noop_reg;
   assign rsp_zone_field = st_reg.rsp_zone_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   wire d_on = req_valid && data_translate;

   zone_select_a: assert property (
      req_valid && zone_select == 4'h5 |=> rsp_zone_field == $past(st_reg.zone_override_reg[21:20]))
      else $error("zone select 5 did not pick bits 10 and 11");

   user_noacc_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LOAD && problem_state && zone_now == 2'h0 |=> rsp_dsi && !rsp_allow)
      else $error("user load in no-access zone not denied");

   user_plain_a: assert property (
      d_on && req_op == zaoc_pkg::OP_STORE && problem_state && zone_now inside {2'h1, 2'h2}
      |=> rsp_dsi == !$past(tlb_wr))
      else $error("user store in plain zone not judged by write permit");

   priv_plain_a: assert property (
      d_on && req_op == zaoc_pkg::OP_STORE && !problem_state && zone_now inside {2'h0, 2'h1}
      |=> rsp_dsi == !$past(tlb_wr))
      else $error("privileged store in plain zone not judged by write permit");

   priv_open_a: assert property (
      req_valid && instr_translate && req_op == zaoc_pkg::OP_IFETCH && !problem_state && zone_now == 2'h2
      |=> rsp_allow && !rsp_isi)
      else $error("privileged fetch in open zone denied");

   all_open_a: assert property (
      d_on && req_op == zaoc_pkg::OP_STORE && zone_now == 2'h3 |=> rsp_allow && !rsp_dsi)
      else $error("store in fully open zone denied");

   spr_move_a: assert property (
      spr_wr_en && spr_num == 10'h3B0 && !problem_state ##1 spr_rd_en && spr_num == 10'h3B0 && !problem_state
      |=> spr_rdata == $past(spr_wdata, 2))
      else $error("zone override register did not read back written value");

   spr_user_a: assert property (
      spr_wr_en && spr_num == 10'h3B0 && problem_state |=> spr_priv_fault && $stable(st_reg.zone_override_reg))
      else $error("user-mode write changed the zone override register");

   line_inval_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_INVAL && !problem_state
      |=> rsp_dsi == (!$past(tlb_wr) && !($past(zone_now) inside {2'h2, 2'h3})))
      else $error("line invalidate verdict wrong");

   line_zero_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_ZERO && problem_state && zone_now == 2'h0 && tlb_wr |=> rsp_dsi)
      else $error("line zero in user no-access zone not denied");

   data_class_a: assert property (
      d_on && req_op == zaoc_pkg::OP_DCLASS_INVAL && !problem_state && zone_now == 2'h0 && !tlb_wr
      |=> rsp_dsi)
      else $error("data class invalidate on read-only page not denied");

   instr_class_a: assert property (
      req_valid && req_op == zaoc_pkg::OP_ICLASS_INVAL |=> rsp_allow && !rsp_dsi && !rsp_noop)
      else $error("instruction class invalidate denied");

   flush_load_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_FLUSH && zone_now != 2'h0 && !tlb_wr |=> rsp_allow)
      else $error("flush denied by write permit");

   spec_noop_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_ALLOC && !tlb_wr && zone_now inside {2'h0, 2'h1}
      |=> rsp_valid && rsp_noop && !rsp_dsi && !rsp_allow)
      else $error("failed allocate not turned into silent no-op");

   never_deny_a: assert property (
      req_valid && req_op inside {zaoc_pkg::OP_DCACHE_READ, zaoc_pkg::OP_ILINE_INVAL, zaoc_pkg::OP_ICACHE_READ}
      |=> rsp_allow)
      else $error("privileged cache read or line invalidate denied");

   priv_read_a: assert property (
      req_valid && !problem_state && req_op == zaoc_pkg::OP_LOAD |=> rsp_allow && !rsp_dsi)
      else $error("privileged load denied");

   real_mode_a: assert property (
      req_valid && !data_translate && !instr_translate |=> rsp_allow && !rsp_dsi && !rsp_isi && !rsp_noop)
      else $error("check applied in real mode");

   inval_zone_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_INVAL && tlb_wr |=> rsp_allow && !rsp_dsi)
      else $error("line invalidate blocked by zone");

   touch_load_a: assert property (
      d_on && req_op inside {zaoc_pkg::OP_TOUCH, zaoc_pkg::OP_TOUCH_ST, zaoc_pkg::OP_ITOUCH} && !tlb_wr
      && !(problem_state && zone_now == zaoc_pkg::ZF_NO_ACCESS) |=> rsp_allow && !rsp_noop)
      else $error("touch suppressed by write permit");

   line_store_a: assert property (
      d_on && req_op == zaoc_pkg::OP_LINE_STORE && problem_state && zone_now == zaoc_pkg::ZF_NO_ACCESS
      |=> rsp_dsi && !rsp_allow)
      else $error("line store in user no-access zone not denied");

   spr_other_a: assert property (
      (spr_wr_en || spr_rd_en) && spr_num != zaoc_pkg::ZONE_OVR_SPR_NUM
      |=> !spr_priv_fault && $stable(st_reg.zone_override_reg))
      else $error("access to another special register touched the zone register");

   user_fetch_a: assert property (
      req_valid && instr_translate && req_op == zaoc_pkg::OP_IFETCH && problem_state
      && zone_now == zaoc_pkg::ZF_NO_ACCESS |=> rsp_isi && !rsp_allow)
      else $error("user fetch in no-access zone not denied");

   resp_timing_a: assert property (
      req_valid |=> rsp_valid ##0 $onehot({rsp_allow, rsp_dsi, rsp_isi, rsp_noop}))
      else $error("verdict missing or not one-hot one cycle after request");

   user_deny_c:   cover property (d_on && problem_state && zone_now == 2'h0 ##1 rsp_dsi);
   spec_noop_c:   cover property (rsp_noop);
   fetch_isi_c:   cover property (rsp_isi);
   spr_write_c:   cover property (spr_wr_en && spr_num == 10'h3B0 && !problem_state ##1 req_valid);
   class_dsi_c:   cover property (d_on && req_op == zaoc_pkg::OP_DCLASS_INVAL ##1 rsp_dsi);

endmodule : zaoc_checker

// ==== include/zaoc_pkg.sv ====
/*
 * Shared constants and types of the zone access override checker: the
 * special-register number and reset value of the zone override register,
 * the zone field layout and codes, and the set of checked operations.
 * Assumes a 32-bit register with bit 0 as the most significant bit.
 */
package zaoc_pkg;

   // Zone override register location and layout
   localparam logic [9:0]  ZONE_OVR_SPR_NUM = 10'h3B0;
   localparam logic [31:0] ZONE_OVR_RESET   = 32'h0000_0000;
   localparam int          ZONE_COUNT       = 16;
   localparam int          ZONE_FIELD_W     = 2;
   localparam int          ZONE_SEL_W       = 4;
   localparam int          ZONE_REG_W       = 32;

   // Zone field codes
   localparam logic [1:0]  ZF_NO_ACCESS = 2'h0;
   localparam logic [1:0]  ZF_PLAIN     = 2'h1;
   localparam logic [1:0]  ZF_PRIV_OPEN = 2'h2;
   localparam logic [1:0]  ZF_ALL_OPEN  = 2'h3;

   // Operations presented for a protection check
   typedef enum logic [3:0] {
      OP_LOAD,
      OP_STORE,
      OP_IFETCH,
      OP_LINE_ALLOC,
      OP_LINE_FLUSH,
      OP_LINE_INVAL,
      OP_LINE_STORE,
      OP_TOUCH,
      OP_TOUCH_ST,
      OP_LINE_ZERO,
      OP_DCLASS_INVAL,
      OP_DCACHE_READ,
      OP_ILINE_INVAL,
      OP_ITOUCH,
      OP_ICLASS_INVAL,
      OP_ICACHE_READ
   } zaoc_op_t;

endpackage : zaoc_pkg

// ==== rtl/zaoc_zone_rights.sv ====
/*
 * Zone rights decoder: turns one zone field, the privilege mode and the
 * write and execute permits of the matching translation entry into the
 * effective rights. Purely combinational; the caller registers results.
 */
`timescale 1ns/1ns
module zaoc_zone_rights
(
   input  wire logic [1:0] zone_field,
   input  wire logic       problem_state,
   input  wire logic       tlb_wr,
   input  wire logic       execute_permit,
   output logic            zone_block,
   output logic            wr_ok,
   output logic            ex_ok
);

   logic open_all;

   always_comb
   begin
      // User mode: only 11 opens the page; privileged: 10 and 11 both do
      open_all   = (zone_field == zaoc_pkg::ZF_ALL_OPEN) ||
                   (!problem_state && zone_field == zaoc_pkg::ZF_PRIV_OPEN);
      // No-access only ever applies in user mode
      zone_block = problem_state && (zone_field == zaoc_pkg::ZF_NO_ACCESS);
      wr_ok      = tlb_wr || open_all;
      ex_ok      = execute_permit || open_all;
   end

endmodule : zaoc_zone_rights

// ==== test/tb_top.sv ====
/*
 * Self-checking bench of the zone access override checker: register moves,
 * an exhaustive verdict sweep and seeded random requests.
 * Assumes zaoc_checker from rtl/ and zaoc_pkg from include/ are compiled first.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
   $display("FAIL %s exp %0h got %0h", nm, ex, got); n_mismatch++; end end
module tb_top;
   logic                clk = 1'b0;
   logic                rst_b;
   logic [9:0]          spr_num;
   logic                spr_wr_en;
   logic                spr_rd_en;
   logic [31:0]         spr_wdata;
   logic [31:0]         spr_rdata;
   logic                spr_priv_fault;
   logic                problem_state;
   logic                data_translate;
   logic                instr_translate;
   logic                req_valid;
   zaoc_pkg::zaoc_op_t  req_op;
   logic [3:0]          zone_select;
   logic                tlb_wr;
   logic                execute_permit;
   logic                rsp_valid;
   logic                rsp_allow;
   logic                rsp_dsi;
   logic                rsp_isi;
   logic                rsp_noop;
   logic [1:0]          rsp_zone_field;
   logic [31:0]         zreg;
   int                  n_mismatch = 0;
   int                  tests_run = 0;
   int                  cycles = 0;

   zaoc_checker zaoc_checker_i (.clk(clk), .rst_b(rst_b), .spr_num(spr_num), .spr_wr_en(spr_wr_en),
      .spr_rd_en(spr_rd_en), .spr_wdata(spr_wdata), .spr_rdata(spr_rdata), .spr_priv_fault(spr_priv_fault),
      .problem_state(problem_state), .data_translate(data_translate), .instr_translate(instr_translate),
      .req_valid(req_valid), .req_op(req_op), .zone_select(zone_select), .tlb_wr(tlb_wr),
      .execute_permit(execute_permit), .rsp_valid(rsp_valid), .rsp_allow(rsp_allow), .rsp_dsi(rsp_dsi),
      .rsp_isi(rsp_isi), .rsp_noop(rsp_noop), .rsp_zone_field(rsp_zone_field));

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Expected verdict as {allow, dsi, isi, noop}
   function automatic logic [3:0] verdict(input zaoc_pkg::zaoc_op_t op, input logic [1:0] zf, input logic ps,
                                          input logic wr, input logic ex, input logic dt, input logic it);
      logic zb, wok, eok, d, i, n;
      zb  = ps & (zf == 2'h0);
      wok = wr | (zf == 2'h3) | (!ps & (zf == 2'h2));
      eok = ex | (zf == 2'h3) | (!ps & (zf == 2'h2));
      d   = 1'b0;
      i   = 1'b0;
      n   = 1'b0;
      case (op)
         zaoc_pkg::OP_LOAD, zaoc_pkg::OP_LINE_FLUSH, zaoc_pkg::OP_LINE_STORE: d = zb;
         zaoc_pkg::OP_STORE, zaoc_pkg::OP_LINE_ZERO: d = zb | !wok;
         zaoc_pkg::OP_LINE_INVAL, zaoc_pkg::OP_DCLASS_INVAL: d = !wok;
         zaoc_pkg::OP_IFETCH: i = zb | !eok;
         zaoc_pkg::OP_LINE_ALLOC: n = zb | !wok;
         zaoc_pkg::OP_TOUCH, zaoc_pkg::OP_TOUCH_ST, zaoc_pkg::OP_ITOUCH: n = zb;
         default: d = 1'b0;
      endcase
      // Real mode bypasses every check on the side that is untranslated
      if (!((op == zaoc_pkg::OP_IFETCH) ? it : dt))
      begin
         d = 1'b0;
         i = 1'b0;
         n = 1'b0;
      end
      return {!(d | i | n), d, i, n};
   endfunction : verdict

   ////////////////////////////////////////////////////////////////////////////
   // Drivers: req and special_purpose_reg leave their request up so the next call runs back to back; idle drops both
   task automatic req(input zaoc_pkg::zaoc_op_t op, input logic [3:0] zs, input logic ps, input logic wr,
                      input logic ex, input logic dt, input logic it);
      logic [1:0] zf;
      logic [3:0] v;
      zf = zreg[31 - 2 * int'(zs) -: 2];
      v  = verdict(op, zf, ps, wr, ex, dt, it);
      req_valid = 1'b1;
      req_op = op;
      zone_select = zs;
      problem_state = ps;
      tlb_wr = wr;
      execute_permit = ex;
      data_translate = dt;
      instr_translate = it;
      @(negedge clk);
      `CHK("rsp_valid", 1'b1, rsp_valid)
      `CHK("verdict", v, {rsp_allow, rsp_dsi, rsp_isi, rsp_noop})
      `CHK("rsp_zone_field", zf, rsp_zone_field)
   endtask : req

   task automatic special_purpose_reg(input logic [9:0] num, input logic wr, input logic [31:0] d, input logic ps);
      logic        hit;
      logic [31:0] ex;
      hit = (num == zaoc_pkg::ZONE_OVR_SPR_NUM);
      ex  = (hit && !ps) ? zreg : 32'h0;
      spr_num = num;
      spr_wr_en = wr;
      spr_rd_en = !wr;
      spr_wdata = d;
      problem_state = ps;
      @(negedge clk);
      if (wr && hit && !ps)
         zreg = d;
      `CHK("spr_priv_fault", hit & ps, spr_priv_fault)
      if (!wr) `CHK("spr_rdata", ex, spr_rdata)
   endtask : special_purpose_reg

   task automatic idle();
      spr_wr_en = 1'b0;
      spr_rd_en = 1'b0;
      req_valid = 1'b0;
      @(negedge clk);
      `CHK("rsp_valid idle", 1'b0, rsp_valid)
      `CHK("spr_priv_fault idle", 1'b0, spr_priv_fault)
   endtask : idle

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////////
   // The whole run takes under 3000 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   initial
   begin
      {rst_b, spr_num, spr_wr_en, spr_rd_en, spr_wdata, problem_state} = '0;
      {data_translate, instr_translate, req_valid, zone_select, tlb_wr, execute_permit} = '0;
      req_op = zaoc_pkg::OP_LOAD;
      zreg = zaoc_pkg::ZONE_OVR_RESET;
      void'($urandom(85));
      repeat (16) @(negedge clk);
      `CHK("reset rsp_valid", 1'b0, rsp_valid)
      rst_b = 1'b1;
      special_purpose_reg(10'h3B0, 1'b0, 32'h0, 1'b0);
      // Fields 00,01,10,11 repeat, so zone n carries code n mod 4
      special_purpose_reg(10'h3B0, 1'b1, 32'h1B1B_1B1B, 1'b0);
      special_purpose_reg(10'h3B0, 1'b0, 32'h0, 1'b0);
      special_purpose_reg(10'h3B0, 1'b1, 32'hFFFF_FFFF, 1'b1);
      special_purpose_reg(10'h3B0, 1'b0, 32'h0, 1'b1);
      special_purpose_reg(10'h3B0, 1'b0, 32'h0, 1'b0);
      special_purpose_reg(10'h3B1, 1'b1, 32'hA5A5_A5A5, 1'b0);
      special_purpose_reg(10'h3B1, 1'b0, 32'h0, 1'b0);
      idle();
      for (int k = 0; k < 2048; k++)
         req(zaoc_pkg::zaoc_op_t'(k[3:0]), {2'($urandom), k[5:4]}, k[6], k[7], k[8], k[9], k[10]);
      idle();
      // Class invalidates issued the way software should, with data translation off
      for (int c = 0; c < 4; c++)
      begin
         req(zaoc_pkg::OP_DCLASS_INVAL, 4'($urandom), c[0], c[1], 1'b0, 1'b0, 1'b1);
         req(zaoc_pkg::OP_ICLASS_INVAL, 4'($urandom), c[0], c[1], 1'b0, 1'b0, 1'b1);
      end
      idle();
      repeat (4)
      begin
         special_purpose_reg(10'h3B0, 1'b1, $urandom, 1'b0);
         special_purpose_reg(10'h3B0, 1'b0, 32'h0, 1'b0);
         idle();
         repeat (100)
            req(zaoc_pkg::zaoc_op_t'(4'($urandom)), 4'($urandom), 1'($urandom), 1'($urandom),
                1'($urandom), 1'($urandom), 1'($urandom));
         for (int z = 0; z < 16; z++)
            req(zaoc_pkg::OP_STORE, 4'(z), 1'($urandom), 1'b0, 1'b0, 1'b1, 1'b1);
         idle();
      end
      conclude();
   end
endmodule : tb_top
